// *** shared/mmdec_map.vh ***
`ifndef MMDEC_MAP_VH
`define MMDEC_MAP_VH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define MMDEC_OFF_MODE      12'h000
`define MMDEC_OFF_PAGE      12'h004
`define MMDEC_OFF_VECTOR    12'h008
`define MMDEC_OFF_STATUS    12'h00C
`define MMDEC_OFF_SWRESET   12'h010

// ---------------------------------------------------------------
// Mode word fields and reset values
// ---------------------------------------------------------------
`define MMDEC_PTR_HI        15
`define MMDEC_PTR_LO        7
`define MMDEC_RAM_OVERLAY_ENABLE_BIT      5
`define MMDEC_PTR_RST       9'h1FF
`define MMDEC_PAGE_RST      7'h00
`define MMDEC_RESET_VEC     16'hFF80

// ---------------------------------------------------------------
// Address bounds
// ---------------------------------------------------------------
`define MMDEC_PAGE0_TOP     16'h007F
`define MMDEC_TOP_LARGE     16'h9FFF
`define MMDEC_TOP_SMALL     16'h3FFF
`define MMDEC_OVL_LARGE     16'h7FFF
`define MMDEC_OVL_SMALL     16'h3FFF
`define MMDEC_HRD_LO        16'h2000
`define MMDEC_HRD_HI        16'h3FFF
`define MMDEC_ROM_LO        16'hC000
`define MMDEC_BLK_SHIFT     13

// ---------------------------------------------------------------
// Target codes
// ---------------------------------------------------------------
`define MMDEC_TGT_EXT       2'h0
`define MMDEC_TGT_RAM       2'h1
`define MMDEC_TGT_ROM       2'h2
`define MMDEC_TGT_BLOCKED   2'h3

`endif

// *** src/mmdec_top.v ***
// What this block does
// R1: RAM is split into 8K-word blocks: five on large variant, two on small.
// R2: RAM serves two reads, or one read and one write, per cycle, shared by all blocks.
// R3: Large variant maps data 0080h-9FFFh on chip; overlay also maps program.
// R4: Small variant maps data 0080h-3FFFh on chip; overlay honoured for program.
// R5: Data addresses outside on-chip RAM become external accesses.
// R6: With overlay on, data page 0 stays out of program space.
// R7: ROM protect blocks ROM access by externally fetched instructions.
// R8: RAM protect: host writes free, host reads only inside 2000h-3FFFh.
// R9: Program space is 128 pages of 64K; page register resets to zero.
// R10: Large variant: low 32K of pages 1-127 external unless overlay on.
// R11: Small variant: low 16K of pages 1-127 external unless overlay on.
// R12: Reset, interrupt or trap loads the vector address into the counter.
// R13: Vector slots are four program words apart.
// R14: After reset the vector table sits at FF80h; movable per 128 words.
// R15: After pointer write, user vectors come from the selected page.
// R16: Pointer is mode word bits 15-7, resets 1FFh, kept by soft reset.
// R17: Hardware reset forces pointer to ones; reset vector always FF80h.
// R18: Vector address is pointer concatenated with four times vector number.
// R19: Protect options are fixed build parameters, not software writable.
`timescale 1ns/1ps
`default_nettype none
`include "mmdec_map.vh"

module mmdec_top #(
    parameter LARGE       = 1,
    parameter ROM_PROTECT = 0,
    parameter RAM_PROTECT = 0,
    parameter AW          = 13
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        prog_req,
    input  wire [15:0] prog_addr,
    input  wire        prog_from_ext,
    input  wire        data_rd_req,
    input  wire [15:0] data_rd_addr,
    input  wire        data_wr_req,
    input  wire [15:0] data_wr_addr,
    input  wire [15:0] data_wr_data,
    input  wire        host_port_req,
    input  wire        host_port_write,
    input  wire [15:0] host_port_addr,
    input  wire [15:0] host_port_wdata,
    input  wire        vec_take,
    input  wire [4:0]  vec_num,
    output reg  [1:0]  prog_target,
    output reg  [22:0] prog_ext_addr,
    output reg  [15:0] prog_rdata,
    output reg  [1:0]  data_rd_target,
    output reg  [15:0] data_rd_data,
    output reg  [1:0]  data_wr_target,
    output reg  [1:0]  host_port_target,
    output reg  [15:0] host_port_rdata,
    output reg         pc_load,
    output reg  [15:0] pc_value
);

    localparam NBLK = (LARGE != 0) ? 5 : 2;                       // [R1]
    localparam DEPTH = (1 << AW);

    // -----------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------
    reg  [8:0]  vector_page_pointer_q;
    reg         ram_overlay_enable_q;
    reg  [6:0]  program_page_extension_q;

    wire        wr_en = psel & penable & pwrite;
    wire [15:0] mode_word = {vector_page_pointer_q, 1'b0, ram_overlay_enable_q, 5'h00};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_page_pointer_q    <= `MMDEC_PTR_RST;              // [R17]
            ram_overlay_enable_q     <= 1'b0;
            program_page_extension_q <= `MMDEC_PAGE_RST;             // [R9]
        end else if (wr_en) begin
            case (paddr)
                `MMDEC_OFF_MODE: begin
                    vector_page_pointer_q <= pwdata[`MMDEC_PTR_HI:`MMDEC_PTR_LO]; // [R16]
                    ram_overlay_enable_q  <= pwdata[`MMDEC_RAM_OVERLAY_ENABLE_BIT];
                end
                `MMDEC_OFF_PAGE: begin
                    program_page_extension_q <= pwdata[6:0];
                end
                `MMDEC_OFF_SWRESET: begin
                    // Soft reset clears overlay and page but keeps the pointer
                    ram_overlay_enable_q     <= 1'b0;                // [R16]
                    program_page_extension_q <= `MMDEC_PAGE_RST;
                end
                default: begin
                end
            endcase
        end
    end

    // -----------------------------------------------------------
    // APB slave
    // -----------------------------------------------------------
    wire map_hit = (paddr == `MMDEC_OFF_MODE) || (paddr == `MMDEC_OFF_PAGE) ||
                   (paddr == `MMDEC_OFF_VECTOR) || (paddr == `MMDEC_OFF_STATUS) ||
                   (paddr == `MMDEC_OFF_SWRESET);
    reg [31:0] rd_mux;
    reg        last_vec_q;
    reg [15:0] last_vec_addr_q;

    // -----------------------------------------------------------
    // Status word
    // -----------------------------------------------------------
    wire        large_flag    = (LARGE != 0);
    wire        ram_prot_flag = (RAM_PROTECT != 0);
    wire        rom_prot_flag = (ROM_PROTECT != 0);                 // [R19]
    wire [3:0]  status_bits   = {last_vec_q, large_flag, ram_prot_flag, rom_prot_flag};

    always @* begin
        case (paddr)
            `MMDEC_OFF_MODE:   rd_mux = {16'h0000, mode_word};
            `MMDEC_OFF_PAGE:   rd_mux = {25'h0, program_page_extension_q};
            `MMDEC_OFF_VECTOR: rd_mux = {16'h0000, last_vec_addr_q};
            `MMDEC_OFF_STATUS: rd_mux = {28'h0, status_bits};            // [R19]
            default:           rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~map_hit;
            if (psel & ~penable & ~pwrite)
                prdata <= rd_mux;
        end
    end

    // -----------------------------------------------------------
    // Address decode functions
    // -----------------------------------------------------------
    function [1:0] dec_data;
        input [15:0] a;
        begin
            if (a > `MMDEC_PAGE0_TOP &&
                a <= ((LARGE != 0) ? `MMDEC_TOP_LARGE : `MMDEC_TOP_SMALL)) // [R3] [R4]
                dec_data = `MMDEC_TGT_RAM;
            else
                dec_data = `MMDEC_TGT_EXT;                           // [R5]
        end
    endfunction

    // -----------------------------------------------------------
    // Program fetch decode
    // -----------------------------------------------------------
    wire [15:0] ovl_top = (LARGE != 0) ? `MMDEC_OVL_LARGE : `MMDEC_OVL_SMALL;
    reg  [1:0]  prog_tgt_c;
    always @* begin
        if (ram_overlay_enable_q && prog_addr > `MMDEC_PAGE0_TOP &&
            prog_addr <= ovl_top)                                   // [R6] [R10] [R11]
            prog_tgt_c = `MMDEC_TGT_RAM;
        else if (prog_addr <= ovl_top)
            prog_tgt_c = `MMDEC_TGT_EXT;                             // [R10] [R11]
        else if (program_page_extension_q == `MMDEC_PAGE_RST &&
                 prog_addr >= `MMDEC_ROM_LO)
            prog_tgt_c = (ROM_PROTECT != 0 && prog_from_ext) ?
                         `MMDEC_TGT_BLOCKED : `MMDEC_TGT_ROM;        // [R7]
        else
            prog_tgt_c = `MMDEC_TGT_EXT;
    end

    wire host_rd_ok = (RAM_PROTECT == 0) || host_port_write ||
                      (host_port_addr >= `MMDEC_HRD_LO && host_port_addr <= `MMDEC_HRD_HI); // [R8]
    reg  [1:0]  host_tgt_c;
    reg  [1:0]  data_rd_tgt_c;
    reg  [1:0]  data_wr_tgt_c;
    reg  [1:0]  host_map_c;

    // -----------------------------------------------------------
    // Data and host port decode
    // -----------------------------------------------------------
    always @* begin
        data_rd_tgt_c = dec_data(data_rd_addr);                      // [R3] [R4] [R5]
        data_wr_tgt_c = dec_data(data_wr_addr);                      // [R5]
        host_map_c    = dec_data(host_port_addr);
    end

    // Protected host reads outside the window never reach any memory
    always @* begin
        if (!host_rd_ok)
            host_tgt_c = `MMDEC_TGT_BLOCKED;                         // [R8]
        else if (host_map_c != `MMDEC_TGT_RAM)
            host_tgt_c = `MMDEC_TGT_EXT;
        else
            host_tgt_c = `MMDEC_TGT_RAM;
    end

    // -----------------------------------------------------------
    // Dual-access RAM: one read port, one read/write port shared by all blocks
    // -----------------------------------------------------------
    reg [15:0] ram_mem [0:NBLK*DEPTH-1];                            // [R1]
    wire [15:0] addr_a = data_rd_addr;
    reg  [15:0] addr_b;
    reg  [15:0] b_wdata;

    // Host port has priority on port B, then data write, then fetch
    always @* begin
        if (host_port_req) begin
            addr_b  = host_port_addr;
            b_wdata = host_port_wdata;
        end else if (data_wr_req) begin
            addr_b  = data_wr_addr;
            b_wdata = data_wr_data;
        end else begin
            addr_b  = prog_addr;
            b_wdata = data_wr_data;
        end
    end

    // Block index of each port; only the built blocks answer
    wire [2:0]  blk_a    = addr_a[15:`MMDEC_BLK_SHIFT];
    wire [2:0]  blk_b    = addr_b[15:`MMDEC_BLK_SHIFT];
    wire        blk_a_ok = (blk_a < NBLK);                          // [R1]
    wire        blk_b_ok = (blk_b < NBLK);                          // [R1]

    wire en_a    = data_rd_req && data_rd_tgt_c == `MMDEC_TGT_RAM && blk_a_ok;
    wire en_prog = prog_req && prog_tgt_c == `MMDEC_TGT_RAM && blk_b_ok;
    wire en_hp   = host_port_req && host_tgt_c == `MMDEC_TGT_RAM && blk_b_ok;
    wire en_wr   = data_wr_req && !host_port_req &&
                   data_wr_tgt_c == `MMDEC_TGT_RAM && blk_b_ok;
    wire b_wr    = host_port_req ? (en_hp && host_port_write) : en_wr;
    // Blocked or external accesses leave the read register untouched
    wire rd_b_en = host_port_req ? en_hp : (!data_wr_req && en_prog); // [R8]
    reg  [15:0] rd_a_q;
    reg  [15:0] rd_b_q;

    always @(posedge pclk) begin
        if (en_a)
            rd_a_q <= ram_mem[addr_a];                               // [R2]
        if (b_wr)
            ram_mem[addr_b] <= b_wdata;                              // [R2]
        else if (rd_b_en)
            rd_b_q <= ram_mem[addr_b];
    end

    // -----------------------------------------------------------
    // Decode outputs and vector logic
    // -----------------------------------------------------------
    wire [15:0] vec_addr = {vector_page_pointer_q, vec_num, 2'b00}; // [R13] [R18]

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_target      <= `MMDEC_TGT_EXT;
            prog_ext_addr    <= 23'h0;
            data_rd_target   <= `MMDEC_TGT_EXT;
            data_wr_target   <= `MMDEC_TGT_EXT;
            host_port_target <= `MMDEC_TGT_EXT;
        end else begin
            prog_target      <= prog_tgt_c;
            prog_ext_addr    <= {program_page_extension_q, prog_addr}; // [R9]
            data_rd_target   <= data_rd_tgt_c;
            data_wr_target   <= data_wr_tgt_c;
            host_port_target <= host_tgt_c;
        end
    end

    // -----------------------------------------------------------
    // Vector fetch
    // -----------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_load          <= 1'b1;                                // [R12]
            pc_value         <= `MMDEC_RESET_VEC;                    // [R17]
            last_vec_q       <= 1'b0;
            last_vec_addr_q  <= `MMDEC_RESET_VEC;                    // [R14]
        end else begin
            pc_load          <= vec_take;                            // [R12]
            if (vec_take) begin
                pc_value        <= vec_addr;                         // [R15]
                last_vec_addr_q <= vec_addr;
                last_vec_q      <= 1'b1;
            end
        end
    end

    always @* begin
        prog_rdata      = rd_b_q;
        data_rd_data    = rd_a_q;
        host_port_rdata = rd_b_q;
    end

endmodule
`default_nettype wire

// *** sim/mmdec_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mmdec_core_model (
    input  wire logic        pclk,
    output var  logic        prog_req, prog_from_ext, data_rd_req, data_wr_req,
    output var  logic        host_port_req, host_port_write, vec_take,
    output var  logic [15:0] prog_addr, data_rd_addr, data_wr_addr, data_wr_data,
    output var  logic [15:0] host_port_addr, host_port_wdata,
    output var  logic [4:0]  vec_num
);
    initial begin
        {prog_req, prog_from_ext, data_rd_req, data_wr_req, host_port_req} = 5'h00;
        {host_port_write, vec_take, vec_num} = 7'h00;
    end
    // Bit map of m: 0 fetch, 1 data read, 2 data write, 3 host port, 4 vector
    task go(input logic [4:0] m, input logic [15:0] a, w, d, input logic x);
        begin
            @(posedge pclk);
            {vec_take, host_port_req, data_wr_req, data_rd_req, prog_req} <= m;
            {prog_addr, data_rd_addr, host_port_addr} <= {3{a}};
            {data_wr_addr, data_wr_data, host_port_wdata} <= {w, d, d};
            {prog_from_ext, host_port_write} <= {2{x}};
            vec_num <= a[4:0];
            @(posedge pclk);
            {vec_take, host_port_req, data_wr_req, data_rd_req, prog_req} <= 5'h00;
            // Released buses show no stale value
            {prog_addr, data_rd_addr, host_port_addr} <= {3{~a}};
            {data_wr_addr, data_wr_data, host_port_wdata} <= {~w, ~d, ~d};
            #1;
        end
    endtask
endmodule
`default_nettype wire

// *** sim/mmdec_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mmdec_map.vh"
module mmdec_sva #(parameter LARGE = 1, parameter ROM_PROTECT = 0, parameter RAM_PROTECT = 0) (
    input wire logic        pclk, presetn, prog_req, prog_from_ext, data_rd_req,
    input wire logic        host_port_req, host_port_write, vec_take, pc_load,
    input wire logic [15:0] prog_addr, data_rd_addr, host_port_addr, pc_value,
    input wire logic [4:0]  vec_num,
    input wire logic [1:0]  prog_target, data_rd_target, host_port_target,
    input wire logic [22:0] prog_ext_addr
);
    wire logic [15:0] top = LARGE ? `MMDEC_TOP_LARGE : `MMDEC_TOP_SMALL;
    wire logic        hout = host_port_req && !host_port_write
                             && (host_port_addr < 16'h2000 || host_port_addr > 16'h3FFF);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    vec_slot_a: assert property (vec_take |=> pc_load
        && pc_value[6:0] == {$past(vec_num), 2'h0}) else $error("vector slot wrong");
    reset_vec_a: assert property ($rose(presetn) |-> pc_value == `MMDEC_RESET_VEC)
        else $error("reset vector wrong");
    data_ram_a: assert property (data_rd_req && data_rd_addr inside {[16'h0080:top]}
        |=> data_rd_target == `MMDEC_TGT_RAM) else $error("data not on chip");
    data_ext_a: assert property (data_rd_req && data_rd_addr > top
        |=> data_rd_target == `MMDEC_TGT_EXT) else $error("data not external");
    host_rd_a: assert property (RAM_PROTECT && hout
        |=> host_port_target == `MMDEC_TGT_BLOCKED) else $error("host read not blocked");
    host_wr_a: assert property (host_port_req && host_port_write
        |=> host_port_target != `MMDEC_TGT_BLOCKED) else $error("host write blocked");
    rom_prot_a: assert property (ROM_PROTECT && prog_req && prog_from_ext
        |=> prog_target != `MMDEC_TGT_ROM) else $error("external fetch reached rom");
    page_zero_a: assert property (prog_req && prog_addr <= `MMDEC_PAGE0_TOP
        |=> prog_target != `MMDEC_TGT_RAM) else $error("page zero in program space");
    ext_addr_a: assert property (prog_req |=> prog_ext_addr[15:0] == $past(prog_addr))
        else $error("program address lost");
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mmdec_map.vh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic        prog_req, prog_from_ext, data_rd_req, data_wr_req, host_port_req;
    logic        host_port_write, vec_take, pc_load;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] prog_addr, data_rd_addr, data_wr_addr, data_wr_data, host_port_addr;
    logic [15:0] host_port_wdata, prog_rdata, data_rd_data, host_port_rdata, pc_value;
    logic [4:0]  vec_num;
    logic [1:0]  prog_target, data_rd_target, data_wr_target, host_port_target;
    logic [22:0] prog_ext_addr;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cyc = 0;
    mmdec_top #(.LARGE(1), .ROM_PROTECT(1), .RAM_PROTECT(1)) i_dut (.*);
    mmdec_core_model i_core (.*);
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_tests++;
            if (got !== exp) begin
                error_cnt++;
                $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        begin
            @(posedge pclk);
            {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (pready !== 1'b1 && n < 50);
            rd = prdata;
            perr = pslverr;
            {psel, penable} <= 2'h0;
            if (pready !== 1'b1) error_cnt++;
        end
    endtask
    task t_vec;
        begin
            i_core.go(5'h10, 16'h0003, 16'h0000, 16'h0000, 1'b0);
            chk({pc_load, pc_value}, {1'b1, 16'hFF8C});
            apb(1'b1, `MMDEC_OFF_MODE, 32'h000002A0);
            i_core.go(5'h10, 16'h001F, 16'h0000, 16'h0000, 1'b0);
            chk(pc_value, 16'h02FC);
            apb(1'b1, `MMDEC_OFF_SWRESET, 32'h00000000);
            apb(1'b0, `MMDEC_OFF_MODE, 32'h00000000);
            chk({rd[15:7], rd[5]}, {9'h005, 1'b0});
        end
    endtask
    task t_reset;
        begin
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
            apb(1'b0, `MMDEC_OFF_MODE, 32'h00000000);
            chk({rd[15:7], rd[5]}, {`MMDEC_PTR_RST, 1'b0});
            apb(1'b0, `MMDEC_OFF_PAGE, 32'h00000000);
            chk(rd[6:0], `MMDEC_PAGE_RST);
            apb(1'b0, 12'h020, 32'h00000000);
            chk(perr, 1'b1);
            i_core.go(5'h10, 16'h0000, 16'h0000, 16'h0000, 1'b0);
            chk(pc_value, `MMDEC_RESET_VEC);
        end
    endtask
    task t_data;
        begin
            i_core.go(5'h06, 16'h0080, 16'h9FFF, 16'hA5C3, 1'b0);
            chk({data_rd_target, data_wr_target}, {2{`MMDEC_TGT_RAM}});
            i_core.go(5'h02, 16'hA000, 16'h0000, 16'h0000, 1'b0);
            chk(data_rd_target, `MMDEC_TGT_EXT);
            i_core.go(5'h06, 16'h9FFF, 16'h2100, 16'h5A3C, 1'b0);
            chk(data_rd_data, 16'hA5C3);
            i_core.go(5'h0A, 16'h2100, 16'h0000, 16'h0000, 1'b0);
            chk({data_rd_data, host_port_rdata}, {2{16'h5A3C}});
        end
    endtask
    task t_prog;
        begin
            apb(1'b1, `MMDEC_OFF_PAGE, 32'h00000005);
            i_core.go(5'h01, 16'h7FFF, 16'h0000, 16'h0000, 1'b0);
            chk({prog_target, prog_ext_addr}, {`MMDEC_TGT_EXT, 23'h057FFF});
            apb(1'b1, `MMDEC_OFF_MODE, 32'h0000FFA0);
            i_core.go(5'h01, 16'h7FFF, 16'h0000, 16'h0000, 1'b0);
            chk(prog_target, `MMDEC_TGT_RAM);
            i_core.go(5'h01, 16'h0040, 16'h0000, 16'h0000, 1'b0);
            chk(prog_target == `MMDEC_TGT_RAM, 1'b0);
            apb(1'b1, `MMDEC_OFF_PAGE, 32'h00000000);
            i_core.go(5'h01, 16'h0100, 16'h0000, 16'h0000, 1'b0);
            chk(prog_target, `MMDEC_TGT_RAM);
            i_core.go(5'h01, 16'h2100, 16'h0000, 16'h0000, 1'b0);
            chk(prog_rdata, 16'h5A3C);
            i_core.go(5'h01, 16'hC000, 16'h0000, 16'h0000, 1'b1);
            chk(prog_target, `MMDEC_TGT_BLOCKED);
            i_core.go(5'h01, 16'hC000, 16'h0000, 16'h0000, 1'b0);
            chk(prog_target, `MMDEC_TGT_ROM);
        end
    endtask
    task t_host;
        begin
            i_core.go(5'h08, 16'h1000, 16'h0000, 16'h0000, 1'b0);
            chk(host_port_target, `MMDEC_TGT_BLOCKED);
            chk(host_port_rdata, 16'h5A3C);
            i_core.go(5'h08, 16'h3FFF, 16'h0000, 16'h0000, 1'b0);
            chk(host_port_target, `MMDEC_TGT_RAM);
            i_core.go(5'h08, 16'h1000, 16'h0000, 16'h1234, 1'b1);
            chk(host_port_target, `MMDEC_TGT_RAM);
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_vec();
        t_reset();
        t_data();
        t_prog();
        t_host();
        conclude();
    end
endmodule
bind mmdec_top mmdec_sva #(.LARGE(LARGE), .ROM_PROTECT(ROM_PROTECT),
    .RAM_PROTECT(RAM_PROTECT)) i_sva (.*);
`default_nettype wire
